// *** serial_handshake_sequencer.sv ***
// modem-control sequencer for one serial port, with APB register access
// ****************************************
// Overview of operation
// - handshake settings latched when port opens
// - pulse mode: RTS off at open, on sending
// - pulse, both gates: RTS drops after data
// - CTS watched only while sending
// - DSR looked at only when send starts
// - CTS low halts after current character
// - CTS high resumes, nothing lost or repeated
// - DSR low at start: send waits pending
// - DSR high at start: transmission begins
// - ignore settings never consult that input
// - receive request raises RTS, no CTS/DSR check
// - RTS on, port open, receiving profile: each received character stored unless the buffer is full
// - close sends queued characters first
// - close discards receive buffer contents
// ****************************************
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module serial_handshake_sequencer
  import serial_hs_pkg::*;
#(
  parameter  bit IS_PRIMARY = 1'b1,
  parameter  int DEPTH      = FIFO_DEPTH,
  localparam int CW         = $clog2(DEPTH + 1)
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cts,
  input  wire logic              dsr,
  output logic                   rts,
  output logic                   dtr,
  output logic      [CHAR_W-1:0] txChar,
  output logic                   txStart,
  input  wire logic              txDone,
  input  wire logic [CHAR_W-1:0] rxChar,
  input  wire logic              rxValid
);

  // ****************************************
  // declarations
  // ****************************************
  localparam hs_cfg_s CFG_DEFAULT = IS_PRIMARY ? CFG_PRI_RESET : CFG_AUX_RESET;

  port_state_e       state;
  hs_cfg_s           cfg;
  hs_cfg_s           cfgShadow;
  logic              ctsSync;
  logic              dsrSync;
  logic              charBusy;
  logic              rxReq;
  logic              rxOvf;
  logic              access;
  logic              wr;
  logic              rd;
  logic              ctrlWr;
  logic              runCmd;
  logic              openCmd;
  logic              closeCmd;
  logic              recvCmd;
  logic              sendCmd;
  logic              clrOvfCmd;
  logic              isOpen;
  logic              sendStart;
  logic              sendEnd;
  logic              recvStart;
  logic              closeDone;
  logic              issue;
  logic              txPush;
  logic              txPushReady;
  logic              txPopValid;
  logic [CHAR_W-1:0] txHead;
  logic [CW-1:0]     txCount;
  logic              txEmpty;
  logic              rxStore;
  logic              rxPushReady;
  logic              rxPopValid;
  logic [CHAR_W-1:0] rxHead;
  logic              rxPop;
  logic [CW-1:0]     rxCount;
  logic              unmapped;

  // ****************************************
  // pin synchronisers and buffers
  // ****************************************
  hs_sync3 u_cts_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (cts),
    .level (ctsSync)
  );

  hs_sync3 u_dsr_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (dsr),
    .level (dsrSync)
  );

  // a run restart empties both queues; closing empties only the receive side
  char_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) u_tx_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .flush     (runCmd),
    .pushValid (txPush),
    .pushData  (pwdata[CHAR_W-1:0]),
    .pushReady (txPushReady),
    .popValid  (txPopValid),
    .popData   (txHead),
    .popReady  (issue),
    .count     (txCount)
  );

  char_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .flush     (runCmd | closeDone),
    .pushValid (rxStore),
    .pushData  (rxChar),
    .pushReady (rxPushReady),
    .popValid  (rxPopValid),
    .popData   (rxHead),
    .popReady  (rxPop),
    .count     (rxCount)
  );

  // ****************************************
  // APB decode
  // ****************************************
  assign access    = psel & penable & pready;
  assign wr        = access & pwrite;
  assign rd        = access & ~pwrite;
  assign ctrlWr    = wr && (paddr == ADDR_CTRL);
  assign runCmd    = ctrlWr & pwdata[CMD_RUN];
  assign openCmd   = ctrlWr & pwdata[CMD_OPEN] & ~pwdata[CMD_RUN];
  assign closeCmd  = ctrlWr & pwdata[CMD_CLOSE] & ~pwdata[CMD_RUN];
  assign recvCmd   = ctrlWr & pwdata[CMD_RECV] & ~pwdata[CMD_RUN];
  assign sendCmd   = ctrlWr & pwdata[CMD_SEND] & ~pwdata[CMD_RUN];
  assign clrOvfCmd = ctrlWr & pwdata[CMD_CLR_OVF];
  // pop only what the setup cycle showed as valid, so a late arrival is never lost
  assign rxPop     = rd && (paddr == ADDR_RXDATA) && prdata[RX_VALID_BIT];

  always_comb begin
    unmapped = 1'b1;
    if (paddr == ADDR_CTRL) begin
      unmapped = 1'b0;
    end else if (paddr == ADDR_CFG) begin
      unmapped = 1'b0;
    end else if (paddr == ADDR_TXDATA) begin
      unmapped = 1'b0;
    end else if (paddr == ADDR_RXDATA) begin
      unmapped = 1'b0;
    end else if (paddr == ADDR_STATUS) begin
      unmapped = 1'b0;
    end
  end

  // no wait state: answer is prepared in the setup cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (unmapped | (pwrite && (paddr == ADDR_TXDATA) &&
                 !txPushReady));
      if (psel && !penable && !pwrite) begin
        if (paddr == ADDR_CFG) begin
          prdata <= {{(32 - CFG_W){1'b0}}, cfgShadow};
        end else if (paddr == ADDR_RXDATA) begin
          prdata <= rxPopValid ? {23'h000000, 1'b1, rxHead} : '0;
        end else if (paddr == ADDR_STATUS) begin
          prdata <= '0;
          prdata[ST_STATE_LSB +: 3]  <= state;
          prdata[ST_RTS]             <= rts;
          prdata[ST_DTR]             <= dtr;
          prdata[ST_CTS]             <= ctsSync;
          prdata[ST_DSR]             <= dsrSync;
          prdata[ST_CHAR_BUSY]       <= charBusy;
          prdata[ST_RX_OVF]          <= rxOvf;
          prdata[ST_RX_REQ]          <= rxReq;
          prdata[ST_TXCNT_LSB +: 8]  <= 8'(txCount);
          prdata[ST_RXCNT_LSB +: 8]  <= 8'(rxCount);
        end else begin
          prdata <= '0;
        end
      end
    end
  end

  // ****************************************
  // configuration
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfgShadow <= CFG_DEFAULT;
    end else if (wr && (paddr == ADDR_CFG)) begin
      cfgShadow <= hs_cfg_s'(pwdata[CFG_W-1:0]);
    end
  end

  // later writes to the shadow do not disturb an open port
  always_ff @(posedge clk) begin
    if (!rstn || runCmd) begin
      cfg <= CFG_DEFAULT;
    end else if (openCmd && (state == PORT_CLOSED)) begin
      cfg <= cfgShadow;
    end
  end

  // ****************************************
  // port sequence
  // ****************************************
  assign isOpen    = state != PORT_CLOSED;
  assign txEmpty   = !txPopValid;
  assign sendStart = (state == PORT_OPEN) && sendCmd && !closeCmd && can_send(cfg.profile);
  assign sendEnd   = (state == PORT_SENDING) && !closeCmd && txEmpty && !charBusy;
  assign recvStart = isOpen && recvCmd && can_recv(cfg.profile) && !rts;
  assign closeDone = ((state == PORT_OPEN) && closeCmd && txEmpty) ||
                     ((state == PORT_DRAIN) && txEmpty && !charBusy);
  assign txPush    = wr && (paddr == ADDR_TXDATA) && isOpen && (state != PORT_DRAIN) &&
                     can_send(cfg.profile);

  always_ff @(posedge clk) begin
    if (!rstn || runCmd) begin
      state <= PORT_CLOSED;
    end else begin
      case (state)
        PORT_CLOSED: begin
          if (openCmd) begin
            state <= PORT_OPEN;
          end
        end
        PORT_OPEN: begin
          if (closeCmd) begin
            state <= txEmpty ? PORT_CLOSED : PORT_DRAIN;
          end else if (sendStart) begin
            // DSR is judged here, at the start of the send, and not again
            state <= (cfg.dsrGate && !dsrSync) ? PORT_DSR_WAIT : PORT_SENDING;
          end
        end
        PORT_DSR_WAIT: begin
          if (closeCmd) begin
            state <= PORT_DRAIN;
          end else if (dsrSync) begin
            state <= PORT_SENDING;
          end
        end
        PORT_SENDING: begin
          if (closeCmd) begin
            state <= PORT_DRAIN;
          end else if (sendEnd) begin
            state <= PORT_OPEN;
          end
        end
        PORT_DRAIN: begin
          if (txEmpty && !charBusy) begin
            state <= PORT_CLOSED;
          end
        end
        default: begin
          state <= PORT_CLOSED;
        end
      endcase
    end
  end

  // ****************************************
  // character pacing
  // ****************************************
  // CTS counts only in the sending state; a drain at close does not wait for it
  assign issue = txPopValid && !charBusy &&
                 (((state == PORT_SENDING) && (!cfg.ctsGate || ctsSync)) ||
                  (state == PORT_DRAIN));

  // the character in flight always completes, so a halt never splits one
  always_ff @(posedge clk) begin
    if (!rstn || runCmd) begin
      charBusy <= 1'b0;
      txStart  <= 1'b0;
      txChar   <= '0;
    end else begin
      txStart <= issue;
      if (issue) begin
        charBusy <= 1'b1;
        txChar   <= txHead;
      end else if (txDone) begin
        charBusy <= 1'b0;
      end
    end
  end

  // ****************************************
  // receive side
  // ****************************************
  assign rxStore = rxValid && rts && isOpen && can_recv(cfg.profile);

  always_ff @(posedge clk) begin
    if (!rstn || runCmd || closeDone) begin
      rxReq <= 1'b0;
    end else if (recvStart && !cfg.rtsHold) begin
      rxReq <= 1'b1;
    end else if (rxStore) begin
      rxReq <= 1'b0;
    end
  end

  // overflow is sticky; a new overflow beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn || runCmd) begin
      rxOvf <= 1'b0;
    end else if (rxStore && !rxPushReady) begin
      rxOvf <= 1'b1;
    end else if (clrOvfCmd) begin
      rxOvf <= 1'b0;
    end
  end

  // ****************************************
  // modem-control outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rts <= IS_PRIMARY;
    end else if (runCmd) begin
      rts <= 1'b0;
    end else if (openCmd && (state == PORT_CLOSED)) begin
      rts <= cfgShadow.rtsHold;
    end else if (closeDone) begin
      rts <= 1'b0;
    end else if (!cfg.rtsHold && isOpen) begin
      if (sendStart) begin
        rts <= 1'b1;
      end else if (recvStart) begin
        rts <= 1'b1;
      end else if (sendEnd && cfg.ctsGate && cfg.dsrGate) begin
        rts <= 1'b0;
      end else if (rxReq && rxStore && (state == PORT_OPEN)) begin
        rts <= 1'b0;
      end
    end
  end

  // primary DTR idles high, auxiliary low; quiet profiles keep DTR off while open
  always_ff @(posedge clk) begin
    if (!rstn || runCmd) begin
      dtr <= IS_PRIMARY;
    end else if (openCmd && (state == PORT_CLOSED)) begin
      dtr <= !is_quiet(cfgShadow.profile);
    end else if (closeDone) begin
      dtr <= IS_PRIMARY;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_send_go;
    sendStart && !runCmd;
  endsequence

  sequence s_drain_ready;
    (state == PORT_SENDING) && !runCmd && !closeCmd && txPopValid && !charBusy;
  endsequence

  a_open_cfg_latch: assert property ((state == PORT_CLOSED) && openCmd && !runCmd |=>
    (cfg == $past(cfgShadow)) && (state == PORT_OPEN))
    else $error("handshake settings not taken at open");

  a_pulse_open_off: assert property ((state == PORT_CLOSED) && openCmd && !runCmd &&
    !cfgShadow.rtsHold |=> !rts ##1 (!rts || sendStart || recvStart || $past(sendStart)
    || $past(recvStart)))
    else $error("pulse mode raised RTS at open");

  a_pulse_send_on: assert property (s_send_go ##0 !cfg.rtsHold |=> rts)
    else $error("pulse mode RTS missing at send start");

  a_both_gate_drop: assert property (sendEnd && !runCmd && !cfg.rtsHold && cfg.ctsGate &&
    cfg.dsrGate |=> !rts && (state == PORT_OPEN))
    else $error("RTS not dropped after send");

  a_cts_halt: assert property (s_drain_ready ##0 cfg.ctsGate && !ctsSync |=>
    !txStart && !charBusy)
    else $error("character started while CTS low");

  a_cts_resume: assert property (s_drain_ready ##0 cfg.ctsGate && ctsSync && !txPush |=>
    txStart && (txChar == $past(txHead)) && (txCount == $past(txCount) - 1'b1))
    else $error("no resume with CTS high");

  a_cts_ignored: assert property (s_drain_ready ##0 !cfg.ctsGate |=> txStart)
    else $error("CTS consulted while ignored");

  a_no_cts_idle: assert property ((state == PORT_OPEN) || (state == PORT_CLOSED) |->
    !issue)
    else $error("character sent outside a send");

  a_dsr_pending: assert property (s_send_go ##0 cfg.dsrGate && !dsrSync |=>
    (state == PORT_DSR_WAIT) && !txStart)
    else $error("send not held for DSR");

  a_dsr_begin: assert property ((state == PORT_DSR_WAIT) && dsrSync && !closeCmd &&
    !runCmd |=> (state == PORT_SENDING))
    else $error("send did not begin on DSR");

  a_dsr_once: assert property ((state == PORT_SENDING) && !dsrSync && !closeCmd &&
    !runCmd && !sendEnd |=> (state == PORT_SENDING))
    else $error("DSR re-examined during send");

  a_close_drain: assert property ((state == PORT_DRAIN) && !txEmpty && !runCmd |=>
    (state == PORT_DRAIN))
    else $error("close finished with data queued");

  a_close_discard: assert property (closeDone && !runCmd |=> (rxCount == '0) &&
    (state == PORT_CLOSED) && !rts)
    else $error("receive buffer kept after close");

  a_rx_store: assert property (rxStore && rxPushReady && !rxPop && !closeDone && !runCmd
    |=> rxCount == $past(rxCount) + 1'b1)
    else $error("received character not stored");

  a_hold_rts: assert property (cfg.rtsHold && isOpen && !closeDone && !runCmd |=> rts)
    else $error("hold mode RTS dropped while open");

  a_dtr_quiet: assert property (isOpen && is_quiet(cfg.profile) |-> !dtr)
    else $error("DTR on for quiet profile");

endmodule
`default_nettype wire

// *** serial_hs_pkg.sv ***
// shared constants, types and helpers for the serial handshake sequencer
package serial_hs_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CFG    = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // command bits of the control register (write-only, self clearing)
  localparam int CMD_RUN     = 0;
  localparam int CMD_OPEN    = 1;
  localparam int CMD_CLOSE   = 2;
  localparam int CMD_RECV    = 3;
  localparam int CMD_SEND    = 4;
  localparam int CMD_CLR_OVF = 5;

  // configuration register: bits [5:0] hold one hs_cfg_s
  localparam int CFG_W = 6;

  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_RTS       = 4;
  localparam int ST_DTR       = 5;
  localparam int ST_CTS       = 6;
  localparam int ST_DSR       = 7;
  localparam int ST_CHAR_BUSY = 8;
  localparam int ST_RX_OVF    = 9;
  localparam int ST_RX_REQ    = 10;
  localparam int ST_TXCNT_LSB = 16;
  localparam int ST_RXCNT_LSB = 24;
  localparam int RX_VALID_BIT = 8;

  localparam int CHAR_W     = 8;
  localparam int FIFO_DEPTH = 16;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    terminal_profile     = 3'b000,
    generic_link_profile = 3'b001,
    key_input_profile    = 3'b010,
    display_out_profile  = 3'b011,
    printer_profile      = 3'b100
  } profile_e;

  typedef enum logic [2:0] {
    PORT_CLOSED   = 3'b000,
    PORT_OPEN     = 3'b001,
    PORT_DSR_WAIT = 3'b010,
    PORT_SENDING  = 3'b011,
    PORT_DRAIN    = 3'b100
  } port_state_e;

  typedef struct packed {
    profile_e profile;
    logic     rtsHold;
    logic     ctsGate;
    logic     dsrGate;
  } hs_cfg_s;

  localparam hs_cfg_s CFG_PRI_RESET = '{terminal_profile, 1'b0, 1'b0, 1'b0};
  localparam hs_cfg_s CFG_AUX_RESET = '{printer_profile, 1'b0, 1'b0, 1'b0};

  function automatic logic can_send(input profile_e p);
    return p != key_input_profile;
  endfunction

  function automatic logic can_recv(input profile_e p);
    return (p != display_out_profile) && (p != printer_profile);
  endfunction

  function automatic logic is_quiet(input profile_e p);
    return (p == display_out_profile) || (p == printer_profile);
  endfunction

endpackage

// *** hs_sync3.sv ***
// three-stage synchroniser for a modem-control input pin
`timescale 1ns/1ps
`default_nettype none
module hs_sync3 (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      level
);
  logic q1;
  logic q2;
  logic q3;

  // q1 feeds q2 only; the level moves once q2 and q3 agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q1    <= 1'b0;
      q2    <= 1'b0;
      q3    <= 1'b0;
      level <= 1'b0;
    end else begin
      q1 <= pin;
      q2 <= q1;
      q3 <= q2;
      if (q2 == q3) begin
        level <= q3;
      end
    end
  end
endmodule
`default_nettype wire

// *** char_fifo.sv ***
// character queue with flush, used for the transmit and receive buffers
`timescale 1ns/1ps
`default_nettype none
module char_fifo #(
  parameter  int WIDTH = 8,
  parameter  int DEPTH = 16,
  localparam int AW    = $clog2(DEPTH),
  localparam int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             flush,
  input  wire logic             pushValid,
  input  wire logic [WIDTH-1:0] pushData,
  output logic                  pushReady,
  output logic                  popValid,
  output logic      [WIDTH-1:0] popData,
  input  wire logic             popReady,
  output logic      [CW-1:0]    count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic             push;
  logic             pop;

  assign push      = pushValid & pushReady;
  assign pop       = popValid & popReady;
  assign pushReady = count != CW'(DEPTH);
  assign popValid  = count != '0;
  assign popData   = mem[rptr];

  // flush beats any push or pop in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn || flush) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= pushData;
    end
  end
endmodule
`default_nettype wire

// *** serial_peer_model.sv ***
// framer and flow-controlled peripheral at the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       txStart,
  input  wire logic [7:0] txChar,
  input  wire logic       drain,
  output logic            txDone,
  output logic            cts
);
  // ****************************************
  // character timing and capture
  // ****************************************
  logic [3:0] busy;
  int         held;
  int         nGot;
  logic [7:0] got [0:15];
  // eight cycles a character, so a full buffer is seen before the next start
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy   <= 4'h0;
      nGot   <= 0;
      txDone <= 1'b0;
    end else if (txStart) begin
      busy   <= 4'h8;
      got[nGot[3:0]] <= txChar;
      nGot   <= nGot + 1;
      txDone <= 1'b0;
    end else if (busy != 4'h0) begin
      busy   <= busy - 4'h1;
      txDone <= (busy == 4'h1);
    end else begin
      txDone <= 1'b0;
    end
  end
  // two-character buffer: cts drops when full, returns once drained
  always_ff @(posedge clk) begin
    if (!rstn || drain) held <= 0;
    else if (txStart) held <= held + 1;
  end
  assign cts = (held < 2);
endmodule
`default_nettype wire

// *** tb_serial_handshake_sequencer.sv ***
// self-checking bench for the serial handshake sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_serial_handshake_sequencer;
  import serial_hs_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, rxChar = 8'h00, txChar;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, err, cts, dsr = 0, rts, dtr;
  logic txStart, txDone, rxValid = 0, drain = 0;
  int errors = 0, numChecks = 0;
  always #4 clk = ~clk;
  serial_handshake_sequencer serial_handshake_sequencer_i (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts(cts), .dsr(dsr),
    .rts(rts), .dtr(dtr), .txChar(txChar), .txStart(txStart), .txDone(txDone),
    .rxChar(rxChar), .rxValid(rxValid));
  serial_peer_model serial_peer_model_i (.clk(clk), .rstn(rstn), .txStart(txStart),
    .txChar(txChar), .drain(drain), .txDone(txDone), .cts(cts));
  // ****************************************
  // helpers
  // ****************************************
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // request held until the edge where pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // one idle edge, so the next call never drives psel twice in one step
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end else begin
      @(posedge clk);
    end
  endtask
  task automatic cmd(input int b);
    apb(1'b1, ADDR_CTRL, 32'h1 << b);
    tick(2);
  endtask
  task automatic waitState(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rdat[2:0] !== s && n < 100);
    chk(rdat[2:0], s);
    if (rdat[2:0] !== s) stop_test();
  endtask
  task automatic rx(input logic [7:0] c);
    rxChar <= c; rxValid <= 1'b1;
    @(posedge clk);
    rxChar <= ~c; rxValid <= 1'b0;
    @(posedge clk);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    tick(12);
    rstn <= 1'b1;
    @(posedge clk);
    chk({rts, dtr}, 2'b11);
    cmd(CMD_RUN);
    chk({rts, dtr}, 2'b01);
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, ADDR_CFG, 32'h0);
    chk(rdat, 32'h0);
    $display("test reset done");
    apb(1'b1, ADDR_CFG, 32'h0c);
    cmd(CMD_OPEN);
    chk({rts, dtr}, 2'b11);
    apb(1'b1, ADDR_CFG, 32'h0b);
    apb(1'b1, ADDR_TXDATA, 32'h41);
    apb(1'b1, ADDR_TXDATA, 32'h42);
    cmd(CMD_SEND);
    waitState(3'd1);
    chk(serial_peer_model_i.got[1], 8'h42);
    chk(rts, 1'b1);
    rx(8'h61);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk(rdat, 32'h161);
    rx(8'h62);
    for (int i = 0; i < 16; i++) rx(8'(8'h30 + i));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdat[ST_RXCNT_LSB +: 8], 8'h10);
    chk(rdat[ST_RX_OVF], 1'b1);
    cmd(CMD_CLR_OVF);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdat[ST_RX_OVF], 1'b0);
    cmd(CMD_CLOSE);
    chk(rts, 1'b0);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk(rdat, 32'h0);
    $display("test hold done");
    drain <= 1'b1;
    apb(1'b1, ADDR_CFG, 32'h0b);
    drain <= 1'b0;
    cmd(CMD_OPEN);
    chk(rts, 1'b0);
    for (int i = 0; i < 3; i++) apb(1'b1, ADDR_TXDATA, 32'h51 + i);
    cmd(CMD_SEND);
    tick(10);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdat[2:0], 3'd2);
    chk(rts, 1'b1);
    dsr <= 1'b1;
    tick(40);
    chk(serial_peer_model_i.nGot, 4);
    dsr <= 1'b0;
    drain <= 1'b1;
    @(posedge clk);
    drain <= 1'b0;
    waitState(3'd1);
    chk(serial_peer_model_i.nGot, 5);
    chk(serial_peer_model_i.got[4], 8'h53);
    chk(rts, 1'b0);
    cmd(CMD_CLOSE);
    $display("test pulse send done");
    apb(1'b1, ADDR_CFG, 32'h08);
    cmd(CMD_OPEN);
    cmd(CMD_RECV);
    chk(rts, 1'b1);
    rx(8'h66);
    tick(2);
    chk(rts, 1'b0);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk(rdat, 32'h166);
    cmd(CMD_CLOSE);
    apb(1'b1, ADDR_CFG, 32'h20);
    cmd(CMD_OPEN);
    chk(dtr, 1'b0);
    cmd(CMD_CLOSE);
    chk({rts, dtr}, 2'b01);
    $display("test receive and profile done");
    apb(1'b1, ADDR_CFG, 32'h0a);
    cmd(CMD_OPEN);
    apb(1'b1, ADDR_TXDATA, 32'h71);
    apb(1'b1, ADDR_TXDATA, 32'h72);
    cmd(CMD_CLOSE);
    waitState(3'd0);
    chk(serial_peer_model_i.nGot, 7);
    chk(serial_peer_model_i.got[6], 8'h72);
    $display("test drain done");
    stop_test();
  end
endmodule
`default_nettype wire
